/* src/cmdif_cfg.svh */
// constants of the command interpreter: opcodes, register offsets, reset values, timing
// assumes inclusion by bare name from the package and the interpreter
`ifndef CMDIF_CFG_SVH
`define CMDIF_CFG_SVH
`define OP_DLSTART 32'hFFFFFF00
`define OP_SWAP 32'hFFFFFF01
`define OP_INTERRUPT 32'hFFFFFF02
`define OP_REGREAD 32'hFFFFFF19
`define OP_MEMWRITE 32'hFFFFFF1A
`define OP_APPEND 32'hFFFFFF1E
`define OP_INFLATE 32'hFFFFFF22
`define OP_COLDSTART 32'hFFFFFF32
`define OP_APILEVEL 32'hFFFFFF63
`define API_DEFAULT 8'h01
`define SWAP_REQ 8'h02
`define LIST_BASE 22'h300000
`define OFF_CMD_WRITE 13'h0000
`define OFF_CMD_READ 13'h0004
`define OFF_LIST_OFF 13'h0008
`define OFF_EXCHANGE 13'h000C
`define OFF_INT_FLAGS 13'h0010
`define OFF_INT_MASK 13'h0014
`define OFF_API_LEVEL 13'h0018
`define OFF_CMD_BUF 13'h1000
`define MS_NS 1000000
`define CLK_NS 50
`endif

/* src/cmdif_pkg.sv */
// types of the command interpreter
// assumes the constants header sits beside it
package cmdif_pkg;
`include "cmdif_cfg.svh"
    // gray codes along fetch -> arg -> exec -> mem/infl
    typedef enum logic [2:0] {
        ST_FETCH = 3'h0,
        ST_ARG = 3'h1,
        ST_EXEC = 3'h3,
        ST_MEM = 3'h2,
        ST_PAY = 3'h6,
        ST_INFL = 3'h7,
        ST_WAIT = 3'h5
    } cmd_state_t;
endpackage : cmdif_pkg

/* src/cmd_interp.sv */
// command interpreter: ring of 32-bit command words written by the host over apb,
// decoded in order; memory traffic goes out on a simple request/acknowledge port.
// assumes a memory system answering mem_req with one mem_ack pulse and an
// external inflate engine that consumes stream words and signals the stream end.
// How it works
// - set-api-level takes the next word as level for later commands
// - level is 1 after reset; host selects 2 before extended commands
// - list start waits until list writable, then zeroes list write offset
// - interrupt command sets command flag unless its mask bit is zero
// - flag never before parameter milliseconds; zero delay raises at once
// - cold start returns the api level to its reset default of 1; other state is kept
// - swap writes value 2 into the list exchange register
// - swap writes nothing to list memory, offset unchanged
// - append copies byte count from general ram into list memory at offset
// - after append, list write offset grows by byte count
// - register read overwrites the result word in the command buffer
// - memory write copies inline bytes to the address, registers included
// - payload padded to a word; padding skipped, decoding resumes aligned
// - read pointer advances per finished command, equals write when idle
// - inflate streams following compressed words, output to general ram
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "cmdif_cfg.svh"
module cmd_interp
    import cmdif_pkg::*;
#(
    parameter int CB_WORDS = 1024,
    parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [12:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory master (general ram, list memory, registers)
    output logic mem_req,
    output logic mem_we,
    output logic [21:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [3:0] mem_be,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // display side
    input wire logic swap_done,
    output logic [7:0] list_exchange_reg,
    output logic [21:0] list_write_offset,
    // inflate engine stream
    output logic infl_valid,
    output logic [31:0] infl_data,
    output logic [21:0] infl_dest,
    input wire logic infl_ready,
    input wire logic infl_done,
    // interrupt
    output logic irq
);
    logic [31:0] cb [0:CB_WORDS-1];
    cmd_state_t st_ff, nxt_st;
    logic [11:0] wr_ff, nxt_wr, rd_ff, nxt_rd, scan_ff, nxt_scan;
    logic [31:0] op_ff, nxt_op, a1_ff, nxt_a1, a2_ff, nxt_a2, cnt_ff, nxt_cnt;
    logic [31:0] dly_ff, nxt_dly, tick_ff, nxt_tick;
    logic [1:0] nargs_ff, nxt_nargs;
    logic argi_ff, nxt_argi;
    logic [9:0] slot_ff, nxt_slot;
    logic [21:0] src_ff, nxt_src, dst_ff, nxt_dst, dl_ff, nxt_dl;
    logic [7:0] swap_ff, nxt_swap, api_ff, nxt_api;
    logic flag_ff, nxt_flag, mask_ff, nxt_mask;
    logic req_ff, nxt_req, we_ff, nxt_we;
    logic [21:0] maddr_ff, nxt_maddr;
    logic [31:0] mwd_ff, nxt_mwd;
    logic [3:0] be_ff, nxt_be;
    logic avail, apb_acc, apb_wr, in_buf, cb_int_we, cb_host_we;
    logic [31:0] word;

    assign avail = scan_ff != wr_ff;
    assign word = cb[scan_ff[11:2]];
    assign in_buf = paddr[12];
    assign cb_int_we = st_ff == ST_MEM && op_ff == `OP_REGREAD && mem_ack && !we_ff;
    // the interpreter's result write owns the buffer port for that cycle
    assign pready = !cb_int_we;
    assign apb_acc = psel && penable && pready;
    assign apb_wr = apb_acc && pwrite;
    assign cb_host_we = apb_wr && in_buf;
    assign irq = flag_ff && mask_ff;
    assign mem_req = req_ff;
    assign mem_we = we_ff;
    assign mem_addr = maddr_ff;
    assign mem_wdata = mwd_ff;
    assign mem_be = be_ff;
    assign list_exchange_reg = swap_ff;
    assign list_write_offset = dl_ff;
    assign infl_dest = dst_ff;
    assign infl_valid = st_ff == ST_INFL && avail;
    assign infl_data = word;

    always_comb begin
        pslverr = 1'b0;
        prdata = 32'h00000000;
        if (in_buf) begin
            prdata = cb[paddr[11:2]];
        end else begin
            unique case (paddr)
                `OFF_CMD_WRITE: prdata = {20'h00000, wr_ff};
                `OFF_CMD_READ: prdata = {20'h00000, rd_ff};
                `OFF_LIST_OFF: prdata = {10'h000, dl_ff};
                `OFF_EXCHANGE: prdata = {24'h000000, swap_ff};
                `OFF_INT_FLAGS: prdata = {31'h00000000, flag_ff};
                `OFF_INT_MASK: prdata = {31'h00000000, mask_ff};
                `OFF_API_LEVEL: prdata = {24'h000000, api_ff};
                default: pslverr = psel && penable;
            endcase
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_scan = scan_ff;
        nxt_op = op_ff;
        nxt_a1 = a1_ff;
        nxt_a2 = a2_ff;
        nxt_cnt = cnt_ff;
        nxt_dly = dly_ff;
        nxt_tick = tick_ff;
        nxt_nargs = nargs_ff;
        nxt_argi = argi_ff;
        nxt_slot = slot_ff;
        nxt_src = src_ff;
        nxt_dst = dst_ff;
        nxt_dl = dl_ff;
        nxt_swap = swap_ff;
        nxt_api = api_ff;
        nxt_flag = flag_ff;
        nxt_mask = mask_ff;
        nxt_req = req_ff;
        nxt_we = we_ff;
        nxt_maddr = maddr_ff;
        nxt_mwd = mwd_ff;
        nxt_be = be_ff;
        if (swap_done) begin
            nxt_swap = 8'h00;
        end
        if (apb_wr && !in_buf) begin
            unique case (paddr)
                `OFF_CMD_WRITE: nxt_wr = {pwdata[11:2], 2'b00};
                `OFF_LIST_OFF: nxt_dl = pwdata[21:0];
                `OFF_INT_FLAGS: nxt_flag = flag_ff && !pwdata[0];
                `OFF_INT_MASK: nxt_mask = pwdata[0];
                default: ;
            endcase
        end
        unique case (st_ff)
            ST_FETCH: begin
                if (avail) begin
                    nxt_op = word;
                    nxt_scan = scan_ff + 12'h004;
                    nxt_argi = 1'b0;
                    unique case (word)
                        `OP_APPEND, `OP_REGREAD, `OP_MEMWRITE: nxt_nargs = 2'h2;
                        `OP_APILEVEL, `OP_INTERRUPT, `OP_INFLATE: nxt_nargs = 2'h1;
                        default: nxt_nargs = 2'h0;
                    endcase
                    nxt_st = (nxt_nargs == 2'h0) ? ST_EXEC : ST_ARG;
                end
            end
            ST_ARG: begin
                if (avail) begin
                    if (argi_ff) begin
                        nxt_a2 = word;
                        nxt_slot = scan_ff[11:2];
                    end else begin
                        nxt_a1 = word;
                    end
                    nxt_scan = scan_ff + 12'h004;
                    nxt_argi = 1'b1;
                    if ({1'b0, argi_ff} + 2'h1 == nargs_ff) begin
                        nxt_st = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                nxt_st = ST_FETCH;
                unique case (op_ff)
                    `OP_APILEVEL: nxt_api = a1_ff[7:0];
                    `OP_DLSTART: begin
                        if (swap_ff == `SWAP_REQ) begin
                            nxt_st = ST_EXEC;
                        end else begin
                            nxt_dl = 22'h000000;
                        end
                    end
                    `OP_SWAP: nxt_swap = `SWAP_REQ;
                    `OP_INTERRUPT: begin
                        nxt_dly = a1_ff;
                        nxt_tick = 32'h00000000;
                        nxt_st = ST_WAIT;
                    end
                    `OP_COLDSTART: nxt_api = `API_DEFAULT;
                    `OP_APPEND: begin
                        nxt_src = a1_ff[21:0];
                        nxt_dst = `LIST_BASE + dl_ff;
                        nxt_cnt = a2_ff;
                        nxt_st = ST_MEM;
                    end
                    `OP_REGREAD: begin
                        nxt_src = a1_ff[21:0];
                        nxt_cnt = 32'h00000004;
                        nxt_st = ST_MEM;
                    end
                    `OP_MEMWRITE: begin
                        nxt_dst = a1_ff[21:0];
                        nxt_cnt = a2_ff;
                        nxt_st = ST_PAY;
                    end
                    // hand stream to the inflate engine
                    `OP_INFLATE: begin
                        nxt_dst = a1_ff[21:0];
                        nxt_st = ST_INFL;
                    end
                    default: ;
                endcase
            end
            ST_WAIT: begin
                if (dly_ff == 32'h00000000) begin
                    // masked flag stays clear
                    // builds on nxt_flag so a same-cycle masked clear is not lost
                    nxt_flag = nxt_flag || mask_ff;
                    nxt_st = ST_FETCH;
                end else if (tick_ff == 32'(MS_CYCLES - 1)) begin
                    nxt_tick = 32'h00000000;
                    nxt_dly = dly_ff - 32'h00000001;
                end else begin
                    nxt_tick = tick_ff + 32'h00000001;
                end
            end
            ST_MEM: begin
                if (!req_ff) begin
                    if (cnt_ff == 32'h00000000) begin
                        if (op_ff == `OP_APPEND) begin
                            nxt_dl = dl_ff + a2_ff[21:0];
                        end
                        nxt_st = ST_FETCH;
                    end else begin
                        nxt_req = 1'b1;
                        nxt_we = 1'b0;
                        nxt_be = 4'hF;
                        nxt_maddr = src_ff;
                    end
                end else if (mem_ack) begin
                    if (we_ff || op_ff == `OP_REGREAD) begin
                        nxt_req = 1'b0;
                        nxt_we = 1'b0;
                        nxt_src = src_ff + 22'h000004;
                        nxt_dst = dst_ff + 22'h000004;
                        nxt_cnt = cnt_ff - 32'h00000004;
                    end else begin
                        nxt_we = 1'b1;
                        nxt_maddr = dst_ff;
                        nxt_mwd = mem_rdata;
                    end
                end
            end
            ST_PAY: begin
                if (!req_ff) begin
                    if (cnt_ff == 32'h00000000) begin
                        nxt_st = ST_FETCH;
                    end else if (avail) begin
                        // a partial last word consumes its padding too
                        nxt_req = 1'b1;
                        nxt_we = 1'b1;
                        nxt_maddr = dst_ff;
                        nxt_mwd = word;
                        nxt_scan = scan_ff + 12'h004;
                        unique case (cnt_ff)
                            32'h00000001: nxt_be = 4'h1;
                            32'h00000002: nxt_be = 4'h3;
                            32'h00000003: nxt_be = 4'h7;
                            default: nxt_be = 4'hF;
                        endcase
                    end
                end else if (mem_ack) begin
                    nxt_req = 1'b0;
                    nxt_we = 1'b0;
                    nxt_dst = dst_ff + 22'h000004;
                    nxt_cnt = (cnt_ff < 32'h00000004) ? 32'h00000000 : cnt_ff - 32'h00000004;
                end
            end
            ST_INFL: begin
                if (infl_valid && infl_ready) begin
                    nxt_scan = scan_ff + 12'h004;
                end
                if (infl_done) begin
                    nxt_st = ST_FETCH;
                end
            end
        endcase
        // publish the read pointer only when a command ends
        if (nxt_st == ST_FETCH && st_ff != ST_FETCH) begin
            nxt_rd = nxt_scan;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= ST_FETCH;
            wr_ff <= 12'h000;
            rd_ff <= 12'h000;
            scan_ff <= 12'h000;
            op_ff <= 32'h00000000;
            a1_ff <= 32'h00000000;
            a2_ff <= 32'h00000000;
            cnt_ff <= 32'h00000000;
            dly_ff <= 32'h00000000;
            tick_ff <= 32'h00000000;
            nargs_ff <= 2'h0;
            argi_ff <= 1'b0;
            slot_ff <= 10'h000;
            src_ff <= 22'h000000;
            dst_ff <= 22'h000000;
            dl_ff <= 22'h000000;
            swap_ff <= 8'h00;
            api_ff <= `API_DEFAULT;
            flag_ff <= 1'b0;
            mask_ff <= 1'b0;
            req_ff <= 1'b0;
            we_ff <= 1'b0;
            maddr_ff <= 22'h000000;
            mwd_ff <= 32'h00000000;
            be_ff <= 4'h0;
        end else begin
            st_ff <= nxt_st;
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            scan_ff <= nxt_scan;
            op_ff <= nxt_op;
            a1_ff <= nxt_a1;
            a2_ff <= nxt_a2;
            cnt_ff <= nxt_cnt;
            dly_ff <= nxt_dly;
            tick_ff <= nxt_tick;
            nargs_ff <= nxt_nargs;
            argi_ff <= nxt_argi;
            slot_ff <= nxt_slot;
            src_ff <= nxt_src;
            dst_ff <= nxt_dst;
            dl_ff <= nxt_dl;
            swap_ff <= nxt_swap;
            api_ff <= nxt_api;
            flag_ff <= nxt_flag;
            mask_ff <= nxt_mask;
            req_ff <= nxt_req;
            we_ff <= nxt_we;
            maddr_ff <= nxt_maddr;
            mwd_ff <= nxt_mwd;
            be_ff <= nxt_be;
        end
    end

    // buffer has no reset: contents are whatever the host or a register read wrote
    always_ff @(posedge clk) begin
        if (cb_int_we) begin
            cb[slot_ff] <= mem_rdata;
        end else if (cb_host_we) begin
            cb[paddr[11:2]] <= pwdata;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_api_latch: assert property (
        st_ff == ST_EXEC && op_ff == `OP_APILEVEL |=> api_ff == $past(a1_ff[7:0]))
        else $error("api level not taken");
    chk_dlstart_zero: assert property (
        st_ff == ST_EXEC && op_ff == `OP_DLSTART && swap_ff != `SWAP_REQ && !apb_wr
        |=> dl_ff == 22'h000000 && st_ff == ST_FETCH)
        else $error("list start did not clear offset");
    chk_dlstart_stall: assert property (
        st_ff == ST_EXEC && op_ff == `OP_DLSTART && swap_ff == `SWAP_REQ && !swap_done
        |=> st_ff == ST_EXEC)
        else $error("list start ran while swap pending");
    chk_flag_masked: assert property (
        !mask_ff && !flag_ff |=> !flag_ff)
        else $error("masked command flag was set");
    chk_delay_min: assert property (
        $rose(flag_ff) |-> $past(st_ff) == ST_WAIT && $past(dly_ff) == 32'h00000000)
        else $error("flag raised before delay");
    chk_swap_value: assert property (
        st_ff == ST_EXEC && op_ff == `OP_SWAP |=> swap_ff == `SWAP_REQ)
        else $error("swap did not request exchange");
    chk_swap_keep_off: assert property (
        st_ff == ST_EXEC && op_ff == `OP_SWAP && !apb_wr |=> $stable(dl_ff) && !req_ff)
        else $error("swap touched list memory");
    chk_append_advance: assert property (
        st_ff == ST_MEM && op_ff == `OP_APPEND && !req_ff && cnt_ff == 32'h00000000 && !apb_wr
        |=> dl_ff == $past(dl_ff) + $past(a2_ff[21:0]))
        else $error("offset not advanced after append");
    chk_read_ptr_end: assert property (
        $changed(rd_ff) |-> st_ff == ST_FETCH && $past(st_ff) != ST_FETCH)
        else $error("read pointer moved mid command");
endmodule : cmd_interp

/* test/mem_partner.sv */
// far side model: memory system on the request port and an inflate engine
// assumes one request at a time, held with its qualifiers until acknowledged
`timescale 1ns/100ps
module mem_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // memory port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [21:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    // inflate stream
    input wire logic infl_valid,
    input wire logic [31:0] infl_data,
    output logic infl_ready,
    output logic infl_done,
    // bench control
    input wire logic slow,
    input wire logic [7:0] infl_words
);
    logic [31:0] mem [4096];
    logic [31:0] last_rd = 32'h0;
    logic [31:0] seen [$];
    int wait_cnt = 0;
    int writes = 0;
    int taken = 0;
    bit fin = 0;
    function automatic int ix(input logic [21:0] a);
        return int'({a[21:20], a[11:2]});
    endfunction : ix
    function automatic logic [31:0] peek(input logic [21:0] a);
        return mem[ix(a)];
    endfunction : peek
    task automatic poke(input logic [21:0] a, input logic [31:0] d);
        mem[ix(a)] = d;
    endtask : poke
    initial begin
        foreach (mem[i]) mem[i] = 32'h0;
    end
    // read data only with the acknowledge; otherwise the inverse, never a stale match
    assign mem_rdata = mem_ack ? last_rd : ~last_rd;
    always @(posedge clk) begin
        infl_done <= 1'b0;
        if (!rst_n) begin
            mem_ack <= 1'b0;
            infl_ready <= 1'b0;
            wait_cnt = 0;
        end else begin
            if (mem_ack) begin
                mem_ack <= 1'b0;
                wait_cnt = 0;
            end else if (mem_req && wait_cnt >= (slow ? 4 : 0)) begin
                mem_ack <= 1'b1;
                last_rd <= peek(mem_addr);
                if (mem_we) begin
                    writes++;
                    for (int b = 0; b < 4; b++)
                        if (mem_be[b]) mem[ix(mem_addr)][8*b +: 8] = mem_wdata[8*b +: 8];
                end
            end else if (mem_req) begin
                wait_cnt++;
            end
            if (infl_valid && infl_ready) begin
                seen.push_back(infl_data);
                taken++;
            end
            // a slow engine takes a word only every other cycle
            infl_ready <= taken < int'(infl_words) && !(slow && infl_ready);
            if (taken == int'(infl_words) && infl_words != 8'h0 && !fin) begin
                infl_done <= 1'b1;
                fin = 1;
            end
        end
    end
endmodule : mem_partner

/* test/tb_top.sv */
// testbench: plays the host, filling the command ring over apb
// assumes the partner model answers memory and inflate traffic
`timescale 1ns/100ps
`include "cmdif_cfg.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    typedef struct {logic [12:0] a; logic [31:0] d; logic e;} row_t;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, swap_done = 0, slow = 0;
    logic [12:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, mem_wdata, mem_rdata, infl_data, rq;
    logic [7:0] infl_words = 0, list_exchange_reg;
    logic pready, pslverr, mem_req, mem_we, mem_ack, infl_valid, infl_ready, infl_done, irq, re;
    logic [21:0] mem_addr, list_write_offset, infl_dest;
    logic [3:0] mem_be;
    logic [11:0] wp = 0, slot;
    logic [31:0] iw [3] = '{32'h0DEF1A7E, 32'h12345678, 32'h9ABC0000};
    int num_errors = 0, tests_run = 0, n, wn;
    row_t rows [8] = '{'{13'h0, 0, 0}, '{13'h4, 0, 0}, '{13'h8, 0, 0}, '{13'hC, 0, 0},
        '{13'h10, 0, 0}, '{13'h14, 0, 0}, '{13'h18, 1, 0}, '{13'h20, 0, 1}};
    cmd_interp #(.CB_WORDS(1024), .MS_CYCLES(10)) u_dut (.clk(clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .swap_done(swap_done),
        .list_exchange_reg(list_exchange_reg), .list_write_offset(list_write_offset),
        .infl_valid(infl_valid), .infl_data(infl_data), .infl_dest(infl_dest),
        .infl_ready(infl_ready), .infl_done(infl_done), .irq(irq));
    mem_partner u_mem (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .infl_valid(infl_valid), .infl_data(infl_data),
        .infl_ready(infl_ready), .infl_done(infl_done), .slow(slow), .infl_words(infl_words));
    always #25 clk = ~clk;
    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // setup, then access held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic idle();
        for (int i = 0; i < 300; i++) begin
            apb(1'b0, `OFF_CMD_READ, 32'h0);
            if (rq[11:0] === wp) break;
        end
        `CHK("read_ptr", {20'h0, wp}, rq)
    endtask : idle
    task automatic run(input logic [31:0] w[$], input bit wait_done);
        foreach (w[i]) begin
            apb(1'b1, {1'b1, wp}, w[i]);
            wp = wp + 12'h4;
        end
        apb(1'b1, `OFF_CMD_WRITE, {20'h0, wp});
        if (wait_done) idle();
    endtask : run
    task automatic irq_wait(output int k);
        k = 0;
        while (irq !== 1'b1 && k < 200) begin
            @(posedge clk);
            k++;
        end
    endtask : irq_wait
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        $display("[ERR] watchdog exp done got hang");
        test_done();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            `CHK("reg_reset", rows[i].d, rq)
            `CHK("slverr", rows[i].e, re)
        end
        run({`OP_APILEVEL, 32'h2}, 1);
        apb(1'b0, `OFF_API_LEVEL, 32'h0);
        `CHK("api_set", 32'h2, rq)
        run({`OP_COLDSTART}, 1);
        apb(1'b0, `OFF_API_LEVEL, 32'h0);
        `CHK("api_cold", 32'h1, rq)
        apb(1'b1, `OFF_INT_MASK, 32'h1);
        run({`OP_INTERRUPT, 32'h0}, 0);
        irq_wait(n);
        `CHK("irq_now", 1'b1, n < 12)
        idle();
        apb(1'b1, `OFF_INT_FLAGS, 32'h1);
        @(posedge clk);
        `CHK("irq_clear", 1'b0, irq)
        run({`OP_INTERRUPT, 32'h2}, 0);
        irq_wait(n);
        `CHK("irq_delay", 1'b1, n >= 20 && n < 60)
        idle();
        apb(1'b1, `OFF_INT_FLAGS, 32'h1);
        apb(1'b1, `OFF_INT_MASK, 32'h0);
        run({`OP_INTERRUPT, 32'h0}, 1);
        apb(1'b0, `OFF_INT_FLAGS, 32'h0);
        `CHK("flag_masked", 32'h0, rq)
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, `OFF_LIST_OFF, 32'h40);
        wn = u_mem.writes;
        run({`OP_SWAP}, 1);
        `CHK("exchange", 8'h02, list_exchange_reg)
        `CHK("swap_off", 22'h40, list_write_offset)
        `CHK("swap_mem", wn, u_mem.writes)
        run({`OP_DLSTART}, 0);
        repeat (30) @(posedge clk);
        apb(1'b0, `OFF_CMD_READ, 32'h0);
        `CHK("dl_stall", 1'b1, rq[11:0] != wp)
        `CHK("dl_wait_off", 22'h40, list_write_offset)
        swap_done <= 1'b1;
        @(posedge clk);
        swap_done <= 1'b0;
        idle();
        `CHK("dl_off", 22'h0, list_write_offset)
        `CHK("exchange_clr", 8'h00, list_exchange_reg)
        slow <= 1'b1;
        for (int i = 0; i < 3; i++) u_mem.poke(22'(32'h100 + 4 * i), 32'hA0B0C000 + i);
        run({`OP_APPEND, 32'h100, 32'hC}, 1);
        for (int i = 0; i < 3; i++)
            `CHK("append_word", 32'hA0B0C000 + i, u_mem.peek(22'(`LIST_BASE + 4 * i)))
        `CHK("append_off", 22'hC, list_write_offset)
        u_mem.poke(22'h3F0, 32'hCAFE1234);
        slot = wp + 12'h8;
        run({`OP_REGREAD, 32'h3F0, 32'h0}, 1);
        apb(1'b0, {1'b1, slot}, 32'h0);
        `CHK("regread", 32'hCAFE1234, rq)
        run({`OP_MEMWRITE, 32'h500, 32'h6, 32'h11223344, 32'hEEFF5566, `OP_APILEVEL, 32'h2}, 1);
        `CHK("memw0", 32'h11223344, u_mem.peek(22'h500))
        `CHK("memw1", 32'h00005566, u_mem.peek(22'h504))
        apb(1'b0, `OFF_API_LEVEL, 32'h0);
        `CHK("memw_next", 32'h2, rq)
        infl_words <= 8'h3;
        run({`OP_INFLATE, 32'h800, iw[0], iw[1], iw[2], `OP_COLDSTART}, 1);
        `CHK("infl_dest", 22'h800, infl_dest)
        `CHK("infl_count", 3, u_mem.seen.size())
        foreach (iw[i]) `CHK("infl_word", iw[i], u_mem.seen[i])
        apb(1'b0, `OFF_API_LEVEL, 32'h0);
        `CHK("infl_next", 32'h1, rq)
        // mid-run reset: level falls back to default, ring restarts at zero
        run({`OP_APILEVEL, 32'h2}, 1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wp = 12'h000;
        apb(1'b0, `OFF_API_LEVEL, 32'h0);
        `CHK("api_rst", 32'h1, rq)
        run({`OP_APILEVEL, 32'h2}, 1);
        apb(1'b0, `OFF_API_LEVEL, 32'h0);
        `CHK("api_again", 32'h2, rq)
        test_done();
    end
endmodule : tb_top
